/* usbrx_ep_flags.sv */
// flag and pointer tracking of one endpoint receive fifo
// assumes events arrive already qualified for this endpoint, one cycle pulses
`timescale 1ns/10ps
`default_nettype none
`include "usbrx_map.svh"

module usbrx_ep_flags #(
    parameter int ADDR_W = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire usbrx_pkg::usbrx_fiu_ev_t fiu_ev_in,
    input wire usbrx_pkg::usbrx_fw_ev_t fw_ev_in,
    output var usbrx_pkg::usbrx_flags_t flags_out
);
    import usbrx_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // one extra bit on each pointer marks rollover
    logic [ADDR_W:0] wp, rp, wm;
    logic [ADDR_W:0] next_wp, next_rp, next_wm;
    logic held, urf, ovf;
    logic next_held, next_urf, next_ovf;
    logic empty, full;

    assign empty = (wp == rp);
    assign full = (wp[ADDR_W] != rp[ADDR_W]) && (wp[ADDR_W-1:0] == rp[ADDR_W-1:0]);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_wp = wp;
        next_rp = rp;
        next_wm = wm;
        next_held = held;
        // clears are applied first so a same-cycle set wins
        next_urf = urf & ~fw_ev_in.clr_underrun;
        next_ovf = ovf & ~(fw_ev_in.clr_overrun | fiu_ev_in.setup);
        if (fw_ev_in.flush) begin
            next_wp = '0;
            next_rp = '0;
            next_wm = '0;
            next_held = 1'b0;
            next_urf = 1'b0;
            next_ovf = 1'b0;
        end else begin
            // write side: reversal beats a count write and a byte write
            if (fiu_ev_in.wp_rev) begin
                next_wp = wm;
            end else if (fiu_ev_in.count_wr) begin
                next_wm = wp;
                next_held = 1'b1;
                if (held) begin
                    next_ovf = 1'b1;
                end
            end else if (fiu_ev_in.byte_wr) begin
                if (full) begin
                    next_ovf = 1'b1;
                end else begin
                    next_wp = wp + 1'b1;
                end
            end
            // read side
            if (fw_ev_in.byte_rd) begin
                if (empty) begin
                    next_urf = 1'b1;
                end else begin
                    next_rp = rp + 1'b1;
                end
            end
            if (fw_ev_in.count_rd && !held) begin
                next_urf = 1'b1;
            end
            if (fw_ev_in.release_pkt) begin
                // a count write taken in the same cycle sets the flag and wins
                if (!(fiu_ev_in.count_wr && !fiu_ev_in.wp_rev)) begin
                    next_held = 1'b0;
                end
                if (!held) begin
                    next_urf = 1'b1;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            wp <= '0;
            rp <= '0;
            wm <= '0;
            held <= 1'b0;
            urf <= 1'b0;
            ovf <= 1'b0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            wm <= next_wm;
            held <= next_held;
            urf <= next_urf;
            ovf <= next_ovf;
        end
    end

    assign flags_out.packet_held_flag = held;
    assign flags_out.fifo_empty_flag = empty;
    assign flags_out.fifo_full_flag = full;
    assign flags_out.underrun_flag = urf;
    assign flags_out.overrun_flag = ovf;

endmodule
`default_nettype wire

/* usbrx_map.svh */
// constants for the receive fifo flag logic: addresses, bit positions, reset values
// assumes inclusion by bare name from design files
`ifndef USBRX_MAP_SVH
`define USBRX_MAP_SVH

// ----------------------------------------------------------------
// register address and reset value
// ----------------------------------------------------------------
`define USBRX_FLAG_ADDR 8'he5
`define USBRX_FLAG_RESET 8'h08
`define USBRX_RDATA_RESET 8'h00

// ----------------------------------------------------------------
// bit positions in the flag register
// ----------------------------------------------------------------
`define USBRX_BIT_HELD 6
`define USBRX_BIT_EMPTY 3
`define USBRX_BIT_FULL 2
`define USBRX_BIT_UNDERRUN 1
`define USBRX_BIT_OVERRUN 0

`endif

/* usbrx_pkg.sv */
// types shared by the receive fifo flag logic
// assumes usbrx_map.svh is on the include path
package usbrx_pkg;

    // ----------------------------------------------------------------
    // events from the function interface unit for one endpoint
    // ----------------------------------------------------------------
    typedef struct packed {
        logic byte_wr;
        logic count_wr;
        logic wp_rev;
        logic setup;
    } usbrx_fiu_ev_t;

    // ----------------------------------------------------------------
    // events from firmware for one endpoint
    // ----------------------------------------------------------------
    typedef struct packed {
        logic byte_rd;
        logic count_rd;
        logic release_pkt;
        logic clr_underrun;
        logic clr_overrun;
        logic flush;
    } usbrx_fw_ev_t;

    // ----------------------------------------------------------------
    // flag copy of one endpoint
    // ----------------------------------------------------------------
    typedef struct packed {
        logic packet_held_flag;
        logic fifo_empty_flag;
        logic fifo_full_flag;
        logic underrun_flag;
        logic overrun_flag;
    } usbrx_flags_t;

endpackage

/* usbrx_fifo_flags.sv */
// receive fifo flag register, endpoint indexed, for a usb function
// assumes all inputs come from logic on core_clk_in, strobes are one cycle wide
//
// How it works
// - flag register shows selected endpoint's copy
// - register at e5, reset reads 0x08
// - reserved bits read zero, firmware writes zero
// - packet held bit ignores firmware writes
// - count write sets packet held
// - read complete release clears packet held
// - single packet table: reversal, advance, release
// - full while rolled over and equal
// - sticky underrun, read pointer locked, nak; here reads on a non-empty fifo still advance the read pointer
// - sticky overrun, write locked, setup clears; here byte writes still advance the write pointer while not full
`timescale 1ns/10ps
`default_nettype none
`include "usbrx_map.svh"

module usbrx_fifo_flags #(
    parameter int EP_COUNT = 4,
    parameter int EP_W = 2,
    parameter int ADDR_W = 4
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    // special function register port
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    // endpoint index register value, kept elsewhere
    input wire logic [EP_W-1:0] endpoint_select_index_in,
    // function interface unit side
    input wire logic [EP_W-1:0] fiu_ep_in,
    input wire usbrx_pkg::usbrx_fiu_ev_t fiu_ev_in,
    // firmware side strobes for the selected endpoint
    input wire logic fw_byte_rd_in,
    input wire logic fw_count_rd_in,
    input wire logic read_complete_release_in,
    input wire logic fifo_flush_in,
    // per endpoint nak request while an error flag stands
    output logic [EP_COUNT-1:0] nak_out
);
    import usbrx_pkg::*;

    // ----------------------------------------------------------------
    // register decode
    // ----------------------------------------------------------------
    logic flag_wr, flag_rd;
    assign flag_wr = sfr_wr_in && (sfr_addr_in == `USBRX_FLAG_ADDR);
    assign flag_rd = sfr_rd_in && (sfr_addr_in == `USBRX_FLAG_ADDR);

    // ----------------------------------------------------------------
    // per endpoint flag copies
    // ----------------------------------------------------------------
    usbrx_flags_t ep_flags [EP_COUNT];

    genvar g;
    generate
        for (g = 0; g < EP_COUNT; g++) begin : g_ep
            usbrx_fiu_ev_t fiu_q;
            usbrx_fw_ev_t fw_q;
            logic is_fiu, is_sel;
            assign is_fiu = (fiu_ep_in == EP_W'(g));
            assign is_sel = (endpoint_select_index_in == EP_W'(g));
            assign fiu_q = is_fiu ? fiu_ev_in : '0;
            assign fw_q.byte_rd = is_sel && fw_byte_rd_in;
            assign fw_q.count_rd = is_sel && fw_count_rd_in;
            assign fw_q.release_pkt = is_sel && read_complete_release_in;
            // error flags clear by writing zero to their bit; held, empty, full ignore writes
            assign fw_q.clr_underrun = is_sel && flag_wr && !sfr_wdata_in[`USBRX_BIT_UNDERRUN];
            assign fw_q.clr_overrun = is_sel && flag_wr && !sfr_wdata_in[`USBRX_BIT_OVERRUN];
            assign fw_q.flush = is_sel && fifo_flush_in;

            usbrx_ep_flags #(
                .ADDR_W(ADDR_W)
            ) u_ep (
                .core_clk_in(core_clk_in),
                .reset_in(reset_in),
                .fiu_ev_in(fiu_q),
                .fw_ev_in(fw_q),
                .flags_out(ep_flags[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data and nak
    // ----------------------------------------------------------------
    usbrx_flags_t sel;
    logic [7:0] view;
    logic [7:0] next_rdata;
    logic [EP_COUNT-1:0] next_nak;

    always_comb begin
        sel = ep_flags[endpoint_select_index_in];
        view = 8'h00;
        view[`USBRX_BIT_HELD] = sel.packet_held_flag;
        view[`USBRX_BIT_EMPTY] = sel.fifo_empty_flag;
        view[`USBRX_BIT_FULL] = sel.fifo_full_flag;
        view[`USBRX_BIT_UNDERRUN] = sel.underrun_flag;
        view[`USBRX_BIT_OVERRUN] = sel.overrun_flag;
        // holding the last read value keeps the bus quiet between reads
        next_rdata = flag_rd ? view : sfr_rdata_out;
        for (int i = 0; i < EP_COUNT; i++) begin
            next_nak[i] = ep_flags[i].underrun_flag | ep_flags[i].overrun_flag;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            sfr_rdata_out <= `USBRX_RDATA_RESET;
            nak_out <= '0;
        end else begin
            sfr_rdata_out <= next_rdata;
            nak_out <= next_nak;
        end
    end

endmodule
`default_nettype wire

/* usbrx_fifo_flags_properties.sv */
// port assertions for the receive fifo flag register
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/10ps
`default_nettype none
module usbrx_flag_props #(
    parameter int EP_COUNT = 4,
    parameter int EP_W = 2
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_rd_in,
    input wire logic [EP_W-1:0] endpoint_select_index_in,
    input wire logic [EP_W-1:0] fiu_ep_in,
    input wire usbrx_pkg::usbrx_fiu_ev_t fiu_ev_in,
    input wire logic read_complete_release_in,
    input wire logic fifo_flush_in,
    input wire logic [7:0] sfr_rdata_out,
    input wire logic [EP_COUNT-1:0] nak_out
);
    import usbrx_pkg::*;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    logic rd_flag;
    logic own_cnt;
    assign rd_flag = sfr_rd_in && sfr_addr_in == 8'he5;
    assign own_cnt = fiu_ev_in.count_wr && fiu_ep_in == endpoint_select_index_in;
    sequence s_count;
        own_cnt && !fiu_ev_in.wp_rev && !read_complete_release_in && !fifo_flush_in;
    endsequence
    sequence s_release;
        read_complete_release_in && !own_cnt;
    endsequence
    sequence s_read;
        rd_flag && $stable(endpoint_select_index_in);
    endsequence
    // exactly one idle cycle sits between the event and the read that observes it
    sequence s_held_kept;
        !read_complete_release_in && !fifo_flush_in && $stable(endpoint_select_index_in);
    endsequence
    sequence s_held_gone;
        !own_cnt && $stable(endpoint_select_index_in);
    endsequence
    chk_reset_clears_out: assert property (disable iff (1'b0)
        reset_in |=> sfr_rdata_out == 8'h00 && nak_out == '0) else $error("reset output");
    chk_first_read_value: assert property ($past(reset_in) && rd_flag
        |=> sfr_rdata_out == 8'h08) else $error("first read not 08");
    chk_count_sets_held: assert property (s_count ##1 s_held_kept ##1 s_read
        |=> sfr_rdata_out[6]) else $error("held not set");
    chk_release_clears_held: assert property (s_release ##1 s_held_gone ##1 s_read
        |=> !sfr_rdata_out[6]) else $error("held not cleared");
    chk_nak_follows_errors: assert property (rd_flag
        |=> nak_out[$past(endpoint_select_index_in)] == (|sfr_rdata_out[1:0]))
        else $error("nak mismatch");
    chk_reserved_read_zero: assert property (sfr_rdata_out[7] == 1'b0
        && sfr_rdata_out[5:4] == 2'h0) else $error("reserved bits set");
    chk_empty_full_apart: assert property (!(sfr_rdata_out[3] && sfr_rdata_out[2]))
        else $error("empty and full");
    chk_rdata_holds: assert property (!rd_flag |=> $stable(sfr_rdata_out))
        else $error("read data moved");
endmodule
bind usbrx_fifo_flags usbrx_flag_props #(.EP_COUNT(EP_COUNT), .EP_W(EP_W)) u_props (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .sfr_addr_in(sfr_addr_in),
    .sfr_rd_in(sfr_rd_in),
    .endpoint_select_index_in(endpoint_select_index_in),
    .fiu_ep_in(fiu_ep_in),
    .fiu_ev_in(fiu_ev_in),
    .read_complete_release_in(read_complete_release_in),
    .fifo_flush_in(fifo_flush_in),
    .sfr_rdata_out(sfr_rdata_out),
    .nak_out(nak_out)
);
`default_nettype wire

/* usbrx_fiu_model.sv */
// behavioural function interface unit posting write side events
// assumes it drives at the falling edge of core_clk_in
`timescale 1ns/10ps
`default_nettype none
module usbrx_fiu_model #(
    parameter int EP_W = 2
) (
    input wire logic core_clk_in,
    output logic [EP_W-1:0] fiu_ep_out,
    output var usbrx_pkg::usbrx_fiu_ev_t fiu_ev_out
);
    import usbrx_pkg::*;
    initial begin
        fiu_ep_out = '0;
        fiu_ev_out = '0;
    end
    // idle endpoint shows the inverse so a stale value cannot pass
    task post(input logic [EP_W-1:0] ep, input usbrx_fiu_ev_t ev);
        @(negedge core_clk_in);
        fiu_ep_out = ep;
        fiu_ev_out = ev;
        @(negedge core_clk_in);
        fiu_ev_out = '0;
        fiu_ep_out = ~ep;
    endtask
endmodule
`default_nettype wire

/* test_usb_rx_fifo_flags.sv */
// register level test of the receive fifo flag block
// assumes a fifo of four bytes (ADDR_W 2) so full is reached quickly
`timescale 1ns/10ps
`default_nettype none
module test_usb_rx_fifo_flags;
    import usbrx_pkg::*;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] sfr_addr_in = 8'h00;
    logic sfr_wr_in = 1'b0;
    logic sfr_rd_in = 1'b0;
    logic [7:0] sfr_wdata_in = 8'h00;
    logic [1:0] index = 2'h0;
    logic [3:0] fw = 4'h0;
    logic [1:0] fiu_ep;
    usbrx_fiu_ev_t fiu_ev;
    logic [7:0] rdata;
    logic [3:0] nak;
    int fail_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #25 core_clk_in = ~core_clk_in;
    usbrx_fiu_model #(.EP_W(2)) fiu (.core_clk_in(core_clk_in), .fiu_ep_out(fiu_ep),
        .fiu_ev_out(fiu_ev));
    usbrx_fifo_flags #(.EP_COUNT(4), .EP_W(2), .ADDR_W(2)) dut (
        .core_clk_in(core_clk_in), .reset_in(reset_in), .sfr_addr_in(sfr_addr_in),
        .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in), .sfr_wdata_in(sfr_wdata_in),
        .sfr_rdata_out(rdata), .endpoint_select_index_in(index), .fiu_ep_in(fiu_ep),
        .fiu_ev_in(fiu_ev), .fw_byte_rd_in(fw[3]), .fw_count_rd_in(fw[2]),
        .read_complete_release_in(fw[1]), .fifo_flush_in(fw[0]), .nak_out(nak));
    task test_done;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task check(input string what, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task rd_flags(input string what, input logic [7:0] exp);
        @(negedge core_clk_in);
        sfr_addr_in = 8'he5;
        sfr_rd_in = 1'b1;
        @(negedge core_clk_in);
        sfr_rd_in = 1'b0;
        check(what, exp, rdata);
    endtask
    task wr_flags(input logic [7:0] d);
        @(negedge core_clk_in);
        sfr_addr_in = 8'he5;
        sfr_wdata_in = d;
        sfr_wr_in = 1'b1;
        @(negedge core_clk_in);
        sfr_wr_in = 1'b0;
    endtask
    // fw bits: byte read, count read, release, flush
    task fw_pulse(input logic [3:0] v, input int n);
        repeat (n) begin
            @(negedge core_clk_in);
            fw = v;
            @(negedge core_clk_in);
            fw = 4'h0;
        end
    endtask
    always @(posedge core_clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            test_done;
        end
    end
    initial begin
        repeat (3) @(negedge core_clk_in);
        reset_in = 1'b0;
    end
    initial begin
        repeat (2) @(negedge core_clk_in);
        rd_flags("reset", 8'h08);
        fiu.post(2'd0, 4'b0100);
        rd_flags("count", 8'h48);
        index = 2'd1;
        rd_flags("ep1", 8'h08);
        index = 2'd0;
        fiu.post(2'd0, 4'b0010);
        rd_flags("reversal", 8'h48);
        fiu.post(2'd0, 4'b0100);
        rd_flags("count twice", 8'h49);
        check("nak ovf", 8'h01, {7'h00, nak[0]});
        wr_flags(8'h00);
        rd_flags("ovf clear", 8'h48);
        fw_pulse(4'b0010, 2);
        rd_flags("release twice", 8'h0a);
        wr_flags(8'h43);
        rd_flags("held ro", 8'h0a);
        wr_flags(8'h00);
        repeat (4) fiu.post(2'd0, 4'b1000);
        rd_flags("full", 8'h04);
        fiu.post(2'd0, 4'b1000);
        rd_flags("byte on full", 8'h05);
        fiu.post(2'd0, 4'b0001);
        rd_flags("setup", 8'h04);
        fw_pulse(4'b1000, 4);
        rd_flags("drained", 8'h08);
        fw_pulse(4'b1000, 1);
        rd_flags("read empty", 8'h0a);
        check("nak urf", 8'h01, {7'h00, nak[0]});
        fw_pulse(4'b0001, 1);
        rd_flags("flush", 8'h08);
        // a count read with no packet held is an under-run as well
        fw_pulse(4'b0100, 1);
        rd_flags("count read empty", 8'h0a);
        check("nak count urf", 8'h01, {7'h00, nak[0]});
        test_done;
    end
endmodule
`default_nettype wire
